/* File: aig_bridge.sv */
`timescale 1ns/100ps
module aig_bridge #(
  parameter int QUEUE_DEPTH = 16
) (
  input  wire logic                   i_clock,
  input  wire logic                   i_rst_b,
  input  wire logic [11:0]            i_reg_addr,
  input  wire logic [31:0]            i_reg_wdata,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  output logic [31:0]                 o_reg_rdata,
  output logic                        o_aux_valid,
  output aig_pkg::aig_aux_sym_t       o_aux_sym,
  output logic [7:0]                  o_aux_byte,
  input  wire logic                   i_aux_ready,
  output logic                        o_i2c_valid,
  output aig_pkg::aig_i2c_sym_t       o_i2c_sym,
  output logic [7:0]                  o_i2c_byte,
  input  wire logic                   i_i2c_done,
  input  wire logic                   i_i2c_ack,
  input  wire logic [7:0]             i_i2c_rx,
  output logic                        o_rx_valid,
  output logic [7:0]                  o_rx_byte
);
  import aig_pkg::*;
  localparam int QW = $clog2(QUEUE_DEPTH);

  logic [AIG_CMD_W-1:0]  cmd, next_cmd;
  logic [AIG_ADDR_W-1:0] addr, next_addr;
  logic [7:0]            wq [QUEUE_DEPTH];
  logic [7:0]            next_wq [QUEUE_DEPTH];
  logic [QW:0]           wq_cnt, next_wq_cnt;
  logic [31:0]           next_reg_rdata;
  aig_state_t            state, next_state;
  aig_bus_t              bus, next_bus;
  logic [AIG_DEV_W-1:0]  bus_dev, next_bus_dev;
  logic [QW-1:0]         rd_ptr, next_rd_ptr;
  logic [AIG_LEN_W-1:0]  byte_cnt, next_byte_cnt;
  logic                  addr_lo, next_addr_lo;
  logic                  done, next_done;
  logic                  nack, next_nack;
  logic                  next_aux_valid, next_i2c_valid, next_rx_valid;
  aig_aux_sym_t          next_aux_sym;
  aig_i2c_sym_t          next_i2c_sym;
  logic [7:0]            next_aux_byte, next_i2c_byte, next_rx_byte;

  // decoded command fields
  logic [3:0]           op;
  logic [AIG_LEN_W-1:0] len;
  logic                 is_rd, is_stat, mid_transaction_flag, start, fin, same;
  logic                 aux_acc, i2c_step, last;
  assign op      = cmd[AIG_OP_LSB +: AIG_OP_W];
  assign len     = cmd[AIG_LEN_LSB +: AIG_LEN_W];
  assign is_rd   = op[AIG_OP_RD_BIT];
  assign is_stat = op[AIG_OP_STAT_BIT];
  assign mid_transaction_flag     = op[AIG_OP_MOT_BIT];
  assign aux_acc  = o_aux_valid && i_aux_ready;
  assign i2c_step = o_i2c_valid && i_i2c_done;
  assign last     = byte_cnt == len;
  // bus already open in this direction toward this device
  assign same = (bus_dev == addr[AIG_DEV_W-1:0]) &&
                (bus == (is_rd ? AIG_BUS_READ : AIG_BUS_WRITE));
  // a command write while busy is dropped, the host must wait for done
  assign start = i_reg_wr && i_reg_addr == AIG_OFS_CMD &&
                 state == AIG_ST_IDLE;
  assign fin = (state != AIG_ST_IDLE) && (next_state == AIG_ST_IDLE);

  // host register port: writes, queue pushes, registered read data
  always_comb begin
    next_cmd    = cmd;
    next_addr   = addr;
    next_wq     = wq;
    next_wq_cnt = fin ? '0 : wq_cnt;  // queue is spent by each command
    next_reg_rdata = o_reg_rdata;
    if (i_reg_wr && state == AIG_ST_IDLE) begin
      if (i_reg_addr == AIG_OFS_CMD) begin
        next_cmd = i_reg_wdata[AIG_CMD_W-1:0];
      end else if (i_reg_addr == AIG_OFS_ADDR) begin
        next_addr = i_reg_wdata[AIG_ADDR_W-1:0];
      end else if (i_reg_addr == AIG_OFS_WQ &&
                   wq_cnt < (QW+1)'(QUEUE_DEPTH)) begin
        next_wq[wq_cnt[QW-1:0]] = i_reg_wdata[7:0];
        next_wq_cnt = wq_cnt + 1'b1;
      end
    end
    if (i_reg_rd) begin
      next_reg_rdata = 32'h0;  // unmapped and write-only read as zero
      if (i_reg_addr == AIG_OFS_CMD) begin
        next_reg_rdata[AIG_CMD_W-1:0] = cmd;
        next_reg_rdata[AIG_DONE_BIT]  = done;
        next_reg_rdata[AIG_BUSY_BIT]  = state != AIG_ST_IDLE;
        next_reg_rdata[AIG_NACK_BIT]  = nack;
      end else if (i_reg_addr == AIG_OFS_ADDR) begin
        next_reg_rdata[AIG_ADDR_W-1:0] = addr;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmd         <= AIG_CMD_RST;
      addr        <= AIG_ADDR_RST;
      wq_cnt      <= '0;
      o_reg_rdata <= 32'h0;
      for (int i = 0; i < QUEUE_DEPTH; i++) begin
        wq[i] <= 8'h00;
      end
    end else begin
      cmd         <= next_cmd;
      addr        <= next_addr;
      wq_cnt      <= next_wq_cnt;
      o_reg_rdata <= next_reg_rdata;
      wq          <= next_wq;
    end
  end

  // request framing, then the i2c sequence, then done
  always_comb begin
    next_state     = state;
    next_bus       = bus;
    next_bus_dev   = bus_dev;
    next_rd_ptr    = rd_ptr;
    next_byte_cnt  = byte_cnt;
    next_addr_lo   = addr_lo;
    next_done      = start ? 1'b0 : done;
    next_nack      = start ? 1'b0 : nack;
    next_aux_valid = o_aux_valid;
    next_aux_sym   = o_aux_sym;
    next_aux_byte  = o_aux_byte;
    next_i2c_valid = o_i2c_valid;
    next_i2c_sym   = o_i2c_sym;
    next_i2c_byte  = o_i2c_byte;
    next_rx_valid  = 1'b0;
    next_rx_byte   = o_rx_byte;
    case (state)
      AIG_ST_IDLE: begin
        if (start) begin
          next_state     = AIG_ST_AUX;
          next_aux_valid = 1'b1;
          next_aux_sym   = AIG_AUX_START;
          next_aux_byte  = 8'h00;
          next_addr_lo   = 1'b0;
          next_rd_ptr    = '0;
          next_byte_cnt  = '0;
        end
      end
      AIG_ST_AUX: begin
        if (aux_acc) begin
          case (o_aux_sym)
            AIG_AUX_START: begin
              next_aux_sym  = AIG_AUX_CMD;
              next_aux_byte = {op, addr[19:16]};
            end
            AIG_AUX_CMD: begin
              next_aux_sym  = AIG_AUX_ADDR;
              next_aux_byte = addr[15:8];
            end
            AIG_AUX_ADDR: begin
              if (!addr_lo) begin
                next_addr_lo  = 1'b1;
                next_aux_byte = addr[7:0];
              end else if (is_stat) begin
                next_aux_sym = AIG_AUX_STOP;
              end else begin
                next_aux_sym  = AIG_AUX_LEN;
                next_aux_byte = {4'h0, len};
              end
            end
            AIG_AUX_LEN: begin
              if (is_rd) begin
                next_aux_sym = AIG_AUX_STOP;
              end else begin
                next_aux_sym  = AIG_AUX_DATA;
                next_aux_byte = wq[0];
                next_rd_ptr   = QW'(1);
              end
            end
            AIG_AUX_DATA: begin
              if (last) begin
                next_aux_sym = AIG_AUX_STOP;
              end else begin
                next_aux_byte = wq[rd_ptr];
                next_rd_ptr   = rd_ptr + 1'b1;
                next_byte_cnt = byte_cnt + 1'b1;
              end
            end
            default: begin
              next_aux_valid = 1'b0;
              next_byte_cnt  = '0;
              next_rd_ptr    = QW'(1);
              if (is_stat) begin
                if (!mid_transaction_flag && bus != AIG_BUS_IDLE) begin
                  next_state     = AIG_ST_STOP;
                  next_i2c_valid = 1'b1;
                  next_i2c_sym   = AIG_I2C_STOP;
                end else begin
                  next_state = AIG_ST_IDLE;
                  next_done  = 1'b1;
                end
              end else if (same) begin
                next_state     = AIG_ST_DATA;
                next_i2c_valid = 1'b1;
                next_i2c_sym   = is_rd ? AIG_I2C_RDATA : AIG_I2C_WDATA;
                next_i2c_byte  = is_rd ? 8'h00 : wq[0];
              end else begin
                next_state     = AIG_ST_START;
                next_i2c_valid = 1'b1;
                next_i2c_sym   = bus == AIG_BUS_IDLE ? AIG_I2C_START
                                                     : AIG_I2C_RSTART;
              end
            end
          endcase
        end
      end
      AIG_ST_START: begin
        if (i2c_step) begin
          next_state    = AIG_ST_ADDR;
          next_i2c_sym  = AIG_I2C_ADDR;
          next_i2c_byte = {addr[AIG_DEV_W-1:0], is_rd};
        end
      end
      AIG_ST_ADDR: begin
        if (i2c_step) begin
          if (!i_i2c_ack) begin
            next_nack    = 1'b1;
            next_state   = AIG_ST_STOP;
            next_i2c_sym = AIG_I2C_STOP;
          end else begin
            next_state    = AIG_ST_DATA;
            next_i2c_sym  = is_rd ? AIG_I2C_RDATA : AIG_I2C_WDATA;
            next_i2c_byte = is_rd ? 8'h00 : wq[0];
          end
        end
      end
      AIG_ST_DATA: begin
        if (i2c_step) begin
          if (is_rd) begin
            next_rx_valid = 1'b1;
            next_rx_byte  = i_i2c_rx;
          end
          if (!is_rd && !i_i2c_ack) begin
            // a refused byte ends the burst and closes the bus
            next_nack    = 1'b1;
            next_state   = AIG_ST_STOP;
            next_i2c_sym = AIG_I2C_STOP;
          end else if (last) begin
            next_bus     = is_rd ? AIG_BUS_READ : AIG_BUS_WRITE;
            next_bus_dev = addr[AIG_DEV_W-1:0];
            if (mid_transaction_flag) begin
              next_state     = AIG_ST_IDLE;
              next_i2c_valid = 1'b0;
              next_done      = 1'b1;
            end else begin
              next_state   = AIG_ST_STOP;
              next_i2c_sym = AIG_I2C_STOP;
            end
          end else begin
            next_byte_cnt = byte_cnt + 1'b1;
            next_rd_ptr   = rd_ptr + 1'b1;
            next_i2c_byte = is_rd ? 8'h00 : wq[rd_ptr];
          end
        end
      end
      AIG_ST_STOP: begin
        if (i2c_step) begin
          next_state     = AIG_ST_IDLE;
          next_bus       = AIG_BUS_IDLE;
          next_i2c_valid = 1'b0;
          next_done      = 1'b1;
        end
      end
      default: begin
        next_state = AIG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state       <= AIG_ST_IDLE;
      bus         <= AIG_BUS_IDLE;
      bus_dev     <= '0;
      rd_ptr      <= '0;
      byte_cnt    <= '0;
      addr_lo     <= 1'b0;
      done        <= 1'b0;
      nack        <= 1'b0;
      o_aux_valid <= 1'b0;
      o_aux_sym   <= AIG_AUX_START;
      o_aux_byte  <= 8'h00;
      o_i2c_valid <= 1'b0;
      o_i2c_sym   <= AIG_I2C_START;
      o_i2c_byte  <= 8'h00;
      o_rx_valid  <= 1'b0;
      o_rx_byte   <= 8'h00;
    end else begin
      state       <= next_state;
      bus         <= next_bus;
      bus_dev     <= next_bus_dev;
      rd_ptr      <= next_rd_ptr;
      byte_cnt    <= next_byte_cnt;
      addr_lo     <= next_addr_lo;
      done        <= next_done;
      nack        <= next_nack;
      o_aux_valid <= next_aux_valid;
      o_aux_sym   <= next_aux_sym;
      o_aux_byte  <= next_aux_byte;
      o_i2c_valid <= next_i2c_valid;
      o_i2c_sym   <= next_i2c_sym;
      o_i2c_byte  <= next_i2c_byte;
      o_rx_valid  <= next_rx_valid;
      o_rx_byte   <= next_rx_byte;
    end
  end

  // checks on framing and i2c sequencing
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  a_cmd_starts_req: assert property (start |=> o_aux_valid &&
    o_aux_sym == AIG_AUX_START) else $error("no start after cmd");
  a_len_from_word: assert property (start |=> len ==
    $past(i_reg_wdata[3:0])) else $error("length field wrong");
  a_write_has_data: assert property (aux_acc && o_aux_sym == AIG_AUX_LEN
    && !is_rd |=> o_aux_sym == AIG_AUX_DATA && o_aux_byte == $past(wq[0]))
    else $error("write frame lacks data");
  a_read_no_data: assert property (aux_acc && o_aux_sym == AIG_AUX_LEN
    && is_rd |=> o_aux_sym == AIG_AUX_STOP)
    else $error("read frame carries data");
  a_data_count: assert property (aux_acc && o_aux_sym == AIG_AUX_DATA
    && byte_cnt == len |=> o_aux_sym == AIG_AUX_STOP)
    else $error("data count wrong");
  a_addr_direction: assert property (state == AIG_ST_START && i2c_step
    |=> o_i2c_sym == AIG_I2C_ADDR && o_i2c_byte[0] == is_rd)
    else $error("address phase wrong");
  a_same_skips_addr: assert property (aux_acc && o_aux_sym == AIG_AUX_STOP
    && !is_stat && same |=> state == AIG_ST_DATA)
    else $error("address not skipped");
  a_mot_keeps_open: assert property (state == AIG_ST_DATA && i2c_step &&
    last && mid_transaction_flag && (is_rd || i_i2c_ack) |=> !o_i2c_valid[*2])
    else $error("stop issued with flag");
  a_stop_after_last: assert property (state == AIG_ST_DATA && i2c_step &&
    last && !mid_transaction_flag |=> o_i2c_valid && o_i2c_sym == AIG_I2C_STOP)
    else $error("missing stop");
  a_status_stop: assert property (aux_acc && o_aux_sym == AIG_AUX_STOP &&
    is_stat |=> (o_i2c_valid == ($past(bus) != AIG_BUS_IDLE && !mid_transaction_flag)))
    else $error("status transfer wrong");

  c_write: cover property (state == AIG_ST_DATA && i2c_step && !is_rd);
  c_read: cover property (o_rx_valid && state == AIG_ST_STOP);
  c_status: cover property (aux_acc && o_aux_sym == AIG_AUX_STOP &&
    is_stat);
  c_skip: cover property (aux_acc && o_aux_sym == AIG_AUX_STOP && same);
endmodule

/* File: aig_far_model.sv */
`timescale 1ns/100ps
// stands for the request sink and the i2c engine beyond the bridge
module aig_far_model (
  input  wire logic                  i_clock,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_slow,
  input  wire logic                  i_aux_valid,
  output logic                       o_aux_ready,
  input  wire logic                  i_i2c_valid,
  input  wire aig_pkg::aig_i2c_sym_t i_i2c_sym,
  output logic                       o_i2c_done,
  output logic                       o_i2c_ack,
  output logic [7:0]                 o_i2c_rx
);
  import aig_pkg::*;
  logic [1:0] wait_cnt;
  logic [7:0] rd_cnt;
  logic       next_done;
  // each action takes four cycles, done in the last, so the bridge must hold it
  assign next_done = i_i2c_valid && !o_i2c_done && (wait_cnt == 2'd2);
  // rx shows a changing pattern outside read completions
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_cnt    <= 2'd0;
      rd_cnt      <= 8'h00;
      o_i2c_done  <= 1'b0;
      o_i2c_ack   <= 1'b0;
      o_i2c_rx    <= 8'h00;
      o_aux_ready <= 1'b0;
    end else begin
      o_i2c_done  <= next_done;
      o_i2c_ack   <= next_done;  // slave acks address and data
      o_aux_ready <= i_slow ? ~o_aux_ready : 1'b1;
      if (i_i2c_valid && !o_i2c_done && !next_done) begin
        wait_cnt <= wait_cnt + 2'd1;
      end else begin
        wait_cnt <= 2'd0;
      end
      if (next_done && i_i2c_sym == AIG_I2C_RDATA) begin
        o_i2c_rx <= 8'h3c ^ rd_cnt;  // read bytes
        rd_cnt   <= rd_cnt + 8'h01;
      end else begin
        o_i2c_rx <= ~o_i2c_rx;
      end
    end
  end
endmodule

/* File: aig_pkg.sv */
package aig_pkg;
  // register offsets on the host port
  localparam logic [11:0] AIG_OFS_CMD  = 12'h100;
  localparam logic [11:0] AIG_OFS_WQ   = 12'h104;
  localparam logic [11:0] AIG_OFS_ADDR = 12'h108;
  // command word fields
  localparam int AIG_LEN_LSB  = 0;
  localparam int AIG_LEN_W    = 4;
  localparam int AIG_OP_LSB   = 8;
  localparam int AIG_OP_W     = 4;
  localparam int AIG_FLAG_BIT = 12;
  localparam int AIG_CMD_W    = 13;
  // bits of the op nibble
  localparam int AIG_OP_RD_BIT   = 0;
  localparam int AIG_OP_STAT_BIT = 1;
  localparam int AIG_OP_MOT_BIT  = 2;
  // status bits returned on a command register read
  localparam int AIG_DONE_BIT = 31;
  localparam int AIG_BUSY_BIT = 30;
  localparam int AIG_NACK_BIT = 29;
  // op codes
  localparam logic [3:0] AIG_OP_WR     = 4'h0;
  localparam logic [3:0] AIG_OP_WR_MOT = 4'h4;
  localparam logic [3:0] AIG_OP_RD     = 4'h1;
  localparam logic [3:0] AIG_OP_RD_MOT = 4'h5;
  localparam logic [3:0] AIG_OP_ST     = 4'h2;
  localparam logic [3:0] AIG_OP_ST_MOT = 4'h6;
  // address widths and reset values
  localparam int AIG_ADDR_W = 20;
  localparam int AIG_DEV_W  = 7;
  localparam logic [AIG_CMD_W-1:0]  AIG_CMD_RST  = 13'h0;
  localparam logic [AIG_ADDR_W-1:0] AIG_ADDR_RST = 20'h0;
  // symbols of the request stream and of the i2c stream
  typedef enum logic [2:0] {
    AIG_AUX_START, AIG_AUX_CMD, AIG_AUX_ADDR, AIG_AUX_LEN,
    AIG_AUX_DATA, AIG_AUX_STOP
  } aig_aux_sym_t;
  typedef enum logic [2:0] {
    AIG_I2C_START, AIG_I2C_RSTART, AIG_I2C_ADDR, AIG_I2C_WDATA,
    AIG_I2C_RDATA, AIG_I2C_STOP
  } aig_i2c_sym_t;
  typedef enum logic [1:0] {
    AIG_BUS_IDLE, AIG_BUS_WRITE, AIG_BUS_READ
  } aig_bus_t;
  typedef enum logic [2:0] {
    AIG_ST_IDLE, AIG_ST_AUX, AIG_ST_START, AIG_ST_ADDR, AIG_ST_DATA,
    AIG_ST_STOP
  } aig_state_t;
endpackage

/* File: test_aig_bridge.sv */
`timescale 1ns/100ps
module test_aig_bridge;
  import aig_pkg::*;
  logic                  i_clock, i_rst_b, i_slow, i_reg_wr, i_reg_rd;
  logic [11:0]           i_reg_addr;
  logic [31:0]           i_reg_wdata, o_reg_rdata;
  logic                  o_aux_valid, aux_ready, o_i2c_valid, i2c_done;
  logic                  i2c_ack, o_rx_valid;
  aig_aux_sym_t          o_aux_sym;
  aig_i2c_sym_t          o_i2c_sym;
  logic [7:0]            o_aux_byte, o_i2c_byte, i2c_rx, o_rx_byte;
  logic [10:0]           exp_aux[$], got_aux[$], exp_i2c[$], got_i2c[$];
  logic [10:0]           exp_rx[$], got_rx[$];
  aig_bus_t              bus;
  logic [6:0]            bus_dev;
  int                    num_errors, tests_run, rx_n;
  logic [3:0]            t_op [12] = '{4'h0, 4'h4, 4'h4, 4'h0, 4'h6, 4'h4,
                                       4'h2, 4'h5, 4'h5, 4'h0, 4'h1, 4'h2};
  logic [3:0]            t_len [12] = '{4'h1, 4'h0, 4'hf, 4'h0, 4'h0, 4'h2,
                                        4'h0, 4'h2, 4'h0, 4'h0, 4'h3, 4'h0};
  logic [6:0]            t_dev [12] = '{7'h50, 7'h50, 7'h50, 7'h21, 7'h21,
                                        7'h21, 7'h21, 7'h33, 7'h33, 7'h33,
                                        7'h44, 7'h44};
  logic [31:0]           rd;

  aig_bridge aig_bridge_inst (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_aux_valid(o_aux_valid),
    .o_aux_sym(o_aux_sym), .o_aux_byte(o_aux_byte), .i_aux_ready(aux_ready),
    .o_i2c_valid(o_i2c_valid), .o_i2c_sym(o_i2c_sym),
    .o_i2c_byte(o_i2c_byte), .i_i2c_done(i2c_done), .i_i2c_ack(i2c_ack),
    .i_i2c_rx(i2c_rx), .o_rx_valid(o_rx_valid), .o_rx_byte(o_rx_byte));
  aig_far_model aig_far_model_inst (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_slow(i_slow),
    .i_aux_valid(o_aux_valid), .o_aux_ready(aux_ready),
    .i_i2c_valid(o_i2c_valid), .i_i2c_sym(o_i2c_sym),
    .o_i2c_done(i2c_done), .o_i2c_ack(i2c_ack), .o_i2c_rx(i2c_rx));

  // 20 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  // record every accepted symbol; start and stop bytes carry nothing
  always @(posedge i_clock) begin
    if (o_aux_valid && aux_ready)
      got_aux.push_back({o_aux_sym, (o_aux_sym inside {AIG_AUX_START,
                         AIG_AUX_STOP}) ? 8'h00 : o_aux_byte});
    if (o_i2c_valid && i2c_done)
      got_i2c.push_back({o_i2c_sym, (o_i2c_sym inside {AIG_I2C_ADDR,
                         AIG_I2C_WDATA}) ? o_i2c_byte : 8'h00});
    if (o_rx_valid)
      got_rx.push_back({3'h0, o_rx_byte});
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_q(input string what, input logic [10:0] e[$],
                         input logic [10:0] g[$]);
    check_val({what, " count"}, e.size(), g.size());
    for (int i = 0; i < e.size() && i < g.size(); i++) begin
      check_val(what, {21'h0, e[i]}, {21'h0, g[i]});
    end
  endtask

  // one strobe cycle per access, released at the following edge
  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clock);
    i_reg_wr    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_clock);
    i_reg_rd   <= 1'b0;
    #1 d = o_reg_rdata;
  endtask

  // program one command, wait for done, compare the request, i2c and read byte streams
  task automatic xfer(input logic [3:0] op, input logic [3:0] len,
                      input logic [6:0] dev);
    logic [19:0] addr;
    logic [12:0] cmd;
    logic [31:0] st;
    int          n;
    addr = {4'h9, 8'ha0, 1'b0, dev};
    cmd  = {op[1], op, 4'h0, len};
    n    = int'(len) + 1;
    exp_aux = {};
    exp_i2c = {};
    exp_rx  = {};
    got_aux = {};
    got_i2c = {};
    got_rx  = {};
    reg_wr(AIG_OFS_ADDR, {12'hfff, addr});
    for (int i = 0; i < n && op[1:0] == 2'b00; i++) begin
      reg_wr(AIG_OFS_WQ, {24'hffffff, 8'h70 + 8'(i)});
    end
    reg_wr(AIG_OFS_CMD, {19'h0, cmd});
    exp_aux.push_back({AIG_AUX_START, 8'h00});
    exp_aux.push_back({AIG_AUX_CMD, op, 4'h9});
    exp_aux.push_back({AIG_AUX_ADDR, 8'ha0});
    exp_aux.push_back({AIG_AUX_ADDR, 1'b0, dev});
    if (!op[1]) exp_aux.push_back({AIG_AUX_LEN, 4'h0, len});
    for (int i = 0; i < n && op[1:0] == 2'b00; i++) begin
      exp_aux.push_back({AIG_AUX_DATA, 8'h70 + 8'(i)});
    end
    exp_aux.push_back({AIG_AUX_STOP, 8'h00});
    if (op[1]) begin
      if (!op[2] && bus != AIG_BUS_IDLE) exp_i2c.push_back({AIG_I2C_STOP, 8'h0});
      if (!op[2]) bus = AIG_BUS_IDLE;
    end else begin
      if (bus != (op[0] ? AIG_BUS_READ : AIG_BUS_WRITE) || bus_dev != dev) begin
        exp_i2c.push_back({(bus == AIG_BUS_IDLE) ? AIG_I2C_START :
                           AIG_I2C_RSTART, 8'h00});
        exp_i2c.push_back({AIG_I2C_ADDR, dev, op[0]});
      end
      for (int i = 0; i < n; i++) begin
        if (op[0]) begin
          exp_i2c.push_back({AIG_I2C_RDATA, 8'h00});
          exp_rx.push_back({3'h0, 8'h3c ^ rx_n[7:0]});
          rx_n++;
        end else begin
          exp_i2c.push_back({AIG_I2C_WDATA, 8'h70 + 8'(i)});
        end
      end
      if (!op[2]) exp_i2c.push_back({AIG_I2C_STOP, 8'h00});
      bus = !op[2] ? AIG_BUS_IDLE : (op[0] ? AIG_BUS_READ : AIG_BUS_WRITE);
      bus_dev = dev;
    end
    // only reads until done, no control write in between
    for (n = 0; n < 400; n++) begin
      reg_rd(AIG_OFS_CMD, st);
      if (st[AIG_DONE_BIT] === 1'b1) break;
    end
    if (n == 400) begin
      num_errors++;
      $display("Error done flag expected 1 seen 0");
      end_sim();
    end
    check_val("command readback", {3'b100, 16'h0, cmd}, st);
    check_q("request stream", exp_aux, got_aux);
    check_q("i2c stream", exp_i2c, got_i2c);
    check_q("read bytes", exp_rx, got_rx);
    $display("test op %h len %0d dev %h done", op, len, dev);
  endtask

  initial begin
    i_rst_b     = 1'b0;
    i_slow      = 1'b0;
    i_reg_wr    = 1'b0;
    i_reg_rd    = 1'b0;
    i_reg_addr  = 12'h000;
    i_reg_wdata = 32'h0;
    bus         = AIG_BUS_IDLE;
    bus_dev     = 7'h00;
    repeat (3) @(posedge i_clock);
    i_rst_b <= 1'b1;
    // registers clear at reset, unmapped and queue reads give zero
    reg_rd(AIG_OFS_CMD, rd);
    check_val("command at reset", 32'h0, rd);
    reg_rd(AIG_OFS_ADDR, rd);
    check_val("address at reset", 32'h0, rd);
    reg_rd(12'h10c, rd);
    check_val("unmapped read", 32'h0, rd);
    reg_rd(AIG_OFS_WQ, rd);
    check_val("queue read", 32'h0, rd);
    $display("test reset values done");
    for (int t = 0; t < 12; t++) begin
      i_slow <= t[0];
      xfer(t_op[t], t_len[t], t_dev[t]);
    end
    reg_rd(AIG_OFS_ADDR, rd);
    check_val("address readback", 32'h9a044, rd);
    end_sim();
  end
endmodule
